// ===== src/srq_consts.svh
// register offsets, field positions and reset values for the serial rx status block
`ifndef SRQ_CONSTS_SVH
`define SRQ_CONSTS_SVH

`define SRQ_ADDR_W 9
`define SRQ_OFS_UPD_REQ 9'h120
`define SRQ_OFS_UPD_DONE 9'h121
`define SRQ_OFS_X86_STAT 9'h122
`define SRQ_OFS_X86_IEN 9'h123
`define SRQ_OFS_Q_LOW 9'h124
`define SRQ_OFS_Q_HIGH 9'h125
`define SRQ_OFS_Q_IEN 9'h126
`define SRQ_OFS_Q_STAT 9'h127

`define SRQ_RST_BYTE 8'h00
`define SRQ_FLAGS 4
`define SRQ_FILL_W 24
// 32 packets of 2048 bytes per threshold step
`define SRQ_STEP_SHIFT 16
`define SRQ_CNT_W 32

`define SRQ_BIT_FIFO_OVF 3
`define SRQ_BIT_QUEUE_OVF 2
`define SRQ_BIT_HIGH_X 1
`define SRQ_BIT_LOW_X 0

`endif

// ===== src/srq_pkg.sv
// types shared by the serial rx status block
package srq_pkg;
  typedef logic [7:0] srq_byte_t;
  typedef logic [3:0] srq_flags_t;
  typedef enum logic [1:0] {
    SRQ_UPD_IDLE,
    SRQ_UPD_COPY,
    SRQ_UPD_DONE
  } srq_upd_e;
endpackage : srq_pkg

// ===== src/srq_status_regs.sv
// serial rx monitor update, x86 header mismatch and queue watermark registers
//
// Contract
// - done flag set on finish, cleared by request low
// - request rising edge snapshots counters, resets them
// - sapi high mismatch latched, cleared on read
// - sapi low mismatch latched, cleared on read
// - control field mismatch latched, cleared on read
// - address field mismatch latched, cleared on read
// - mismatch flags interrupt only when enabled
// - low watermark is value times 32 x 2048
// - high watermark is value times 32 x 2048
// - thresholds compare serial-to-ethernet queue fill
// - fifo overflow latched, cleared on read
// - queue overflow latched, cleared on read
// - high crossing latched, cleared on read
// - low crossing latched, cleared on read
// - queue flags interrupt only when enabled
`include "srq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srq_status_regs (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // processor port
  input wire logic [`SRQ_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire srq_pkg::srq_byte_t i_wdata,
  output srq_pkg::srq_byte_t o_rdata,
  // x86 header fields of a received frame
  input wire logic i_hdr_valid,
  input wire srq_pkg::srq_byte_t i_hdr_addr,
  input wire srq_pkg::srq_byte_t i_hdr_ctrl,
  input wire srq_pkg::srq_byte_t i_hdr_sapi_h,
  input wire srq_pkg::srq_byte_t i_hdr_sapi_l,
  input wire srq_pkg::srq_byte_t i_expected_address_field,
  input wire srq_pkg::srq_byte_t i_expected_control_field,
  input wire srq_pkg::srq_byte_t i_expected_sapi_high_octet,
  input wire srq_pkg::srq_byte_t i_expected_sapi_low_octet,
  // serial-to-ethernet queue
  input wire logic [`SRQ_FILL_W-1:0] i_queue_fill,
  input wire logic i_queue_ovf,
  input wire logic i_fifo_ovf,
  // running counters from the receive path
  input wire logic [`SRQ_CNT_W-1:0] i_byte_count,
  input wire logic [`SRQ_CNT_W-1:0] i_abort_count,
  // monitor outputs
  output logic [`SRQ_CNT_W-1:0] o_mon_byte_count,
  output logic [`SRQ_CNT_W-1:0] o_mon_abort_count,
  output logic o_counter_reset,
  output logic o_irq
);
  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  logic rx_monitor_update_request_q;
  srq_pkg::srq_flags_t x86_mismatch_irq_enable_q;
  srq_pkg::srq_byte_t queue_low_watermark_q;
  srq_pkg::srq_byte_t queue_high_watermark_q;
  srq_pkg::srq_flags_t queue_watermark_irq_enable_q;

  // status, done and unmapped addresses take no write
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_monitor_update_request_q <= 1'b0;
    end else if (i_wr && (i_addr == `SRQ_OFS_UPD_REQ)) begin
      rx_monitor_update_request_q <= i_wdata[0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      x86_mismatch_irq_enable_q <= 4'h0;
    end else if (i_wr && (i_addr == `SRQ_OFS_X86_IEN)) begin
      x86_mismatch_irq_enable_q <= i_wdata[3:0];
    end
  end

  // thresholds are whole steps of 32 x 2048 bytes
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      queue_low_watermark_q <= `SRQ_RST_BYTE;
    end else if (i_wr && (i_addr == `SRQ_OFS_Q_LOW)) begin
      queue_low_watermark_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      queue_high_watermark_q <= `SRQ_RST_BYTE;
    end else if (i_wr && (i_addr == `SRQ_OFS_Q_HIGH)) begin
      queue_high_watermark_q <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      queue_watermark_irq_enable_q <= 4'h0;
    end else if (i_wr && (i_addr == `SRQ_OFS_Q_IEN)) begin
      queue_watermark_irq_enable_q <= i_wdata[3:0];
    end
  end

  // ----------------------------------------------------------
  // monitor update sequencing
  // ----------------------------------------------------------
  srq_pkg::srq_upd_e upd_state_q;
  logic req_prev_q;
  logic upd_start;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= rx_monitor_update_request_q;
    end
  end

  // a rising request is only taken while idle; one that rises in copy or done is dropped
  assign upd_start = rx_monitor_update_request_q && !req_prev_q &&
    (upd_state_q == srq_pkg::SRQ_UPD_IDLE);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      upd_state_q <= srq_pkg::SRQ_UPD_IDLE;
    end else begin
      case (upd_state_q)
        srq_pkg::SRQ_UPD_IDLE: begin
          if (upd_start) begin
            upd_state_q <= srq_pkg::SRQ_UPD_COPY;
          end
        end
        // copy state lets the snapshot settle before done rises
        srq_pkg::SRQ_UPD_COPY: begin
          upd_state_q <= srq_pkg::SRQ_UPD_DONE;
        end
        srq_pkg::SRQ_UPD_DONE: begin
          if (!rx_monitor_update_request_q) begin
            upd_state_q <= srq_pkg::SRQ_UPD_IDLE;
          end
        end
        default: begin
          upd_state_q <= srq_pkg::SRQ_UPD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // monitor snapshot and done flag
  // ----------------------------------------------------------
  logic rx_monitor_update_done_flag_q;
  logic [`SRQ_CNT_W-1:0] mon_byte_q;
  logic [`SRQ_CNT_W-1:0] mon_abort_q;
  logic counter_reset_q;

  // snapshot and pulse share the cycle the request is taken
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mon_byte_q <= '0;
      mon_abort_q <= '0;
    end else if (upd_start) begin
      mon_byte_q <= i_byte_count;
      mon_abort_q <= i_abort_count;
    end
  end

  // one-cycle pulse; the running counters clear on it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      counter_reset_q <= 1'b0;
    end else begin
      counter_reset_q <= upd_start;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_monitor_update_done_flag_q <= 1'b0;
    end else if (upd_state_q == srq_pkg::SRQ_UPD_COPY) begin
      rx_monitor_update_done_flag_q <= 1'b1;
    end else if ((upd_state_q == srq_pkg::SRQ_UPD_DONE) &&
        !rx_monitor_update_request_q) begin
      rx_monitor_update_done_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // x86 header mismatch flags
  // ----------------------------------------------------------
  srq_pkg::srq_flags_t x86_event;
  srq_pkg::srq_flags_t x86_flags;
  logic x86_irq;
  logic rd_x86;
  srq_pkg::srq_byte_t hdr_field [`SRQ_FLAGS];
  srq_pkg::srq_byte_t exp_field [`SRQ_FLAGS];

  // index matches the status bit of each field
  assign hdr_field[3] = i_hdr_sapi_h;
  assign exp_field[3] = i_expected_sapi_high_octet;
  assign hdr_field[2] = i_hdr_sapi_l;
  assign exp_field[2] = i_expected_sapi_low_octet;
  assign hdr_field[1] = i_hdr_ctrl;
  assign exp_field[1] = i_expected_control_field;
  assign hdr_field[0] = i_hdr_addr;
  assign exp_field[0] = i_expected_address_field;

  genvar g;
  generate
    for (g = 0; g < `SRQ_FLAGS; g = g + 1) begin : g_hdr_cmp
      assign x86_event[g] = i_hdr_valid && (hdr_field[g] != exp_field[g]);
    end
  endgenerate

  srq_sticky_flags u_x86_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_event(x86_event),
    .i_clear(rd_x86),
    .i_enable(x86_mismatch_irq_enable_q),
    .o_flags(x86_flags),
    .o_irq(x86_irq)
  );

  // ----------------------------------------------------------
  // queue watermark flags
  // ----------------------------------------------------------
  srq_pkg::srq_flags_t q_event;
  srq_pkg::srq_flags_t q_flags;
  logic q_irq;
  logic rd_q;
  logic low_cross;
  logic high_cross;

  // fill is the serial-to-ethernet queue only
  srq_watermark u_low (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_fill(i_queue_fill),
    .i_threshold(queue_low_watermark_q),
    .o_cross(low_cross)
  );

  srq_watermark u_high (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_fill(i_queue_fill),
    .i_threshold(queue_high_watermark_q),
    .o_cross(high_cross)
  );

  assign q_event[`SRQ_BIT_FIFO_OVF] = i_fifo_ovf;
  assign q_event[`SRQ_BIT_QUEUE_OVF] = i_queue_ovf;
  assign q_event[`SRQ_BIT_HIGH_X] = high_cross;
  assign q_event[`SRQ_BIT_LOW_X] = low_cross;

  srq_sticky_flags u_q_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_event(q_event),
    .i_clear(rd_q),
    .i_enable(queue_watermark_irq_enable_q),
    .o_flags(q_flags),
    .o_irq(q_irq)
  );

  // ----------------------------------------------------------
  // read strobes
  // ----------------------------------------------------------
  // a read clears only the status register it addresses
  always_comb begin
    rd_x86 = 1'b0;
    rd_q = 1'b0;
    if (i_rd) begin
      if (i_addr == `SRQ_OFS_X86_STAT) begin
        rd_x86 = 1'b1;
      end else if (i_addr == `SRQ_OFS_Q_STAT) begin
        rd_q = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // read data and outputs
  // ----------------------------------------------------------
  srq_pkg::srq_byte_t rdata_d;
  srq_pkg::srq_byte_t rdata_q;
  logic irq_q;

  // read data shows flags before the clear takes effect
  always_comb begin
    // unmapped addresses and unused bits read as zero
    rdata_d = 8'h00;
    if (i_addr == `SRQ_OFS_UPD_REQ) begin
      rdata_d = {7'h00, rx_monitor_update_request_q};
    end else if (i_addr == `SRQ_OFS_UPD_DONE) begin
      rdata_d = {7'h00, rx_monitor_update_done_flag_q};
    end else if (i_addr == `SRQ_OFS_X86_STAT) begin
      rdata_d = {4'h0, x86_flags};
    end else if (i_addr == `SRQ_OFS_X86_IEN) begin
      rdata_d = {4'h0, x86_mismatch_irq_enable_q};
    end else if (i_addr == `SRQ_OFS_Q_LOW) begin
      rdata_d = queue_low_watermark_q;
    end else if (i_addr == `SRQ_OFS_Q_HIGH) begin
      rdata_d = queue_high_watermark_q;
    end else if (i_addr == `SRQ_OFS_Q_IEN) begin
      rdata_d = {4'h0, queue_watermark_irq_enable_q};
    end else if (i_addr == `SRQ_OFS_Q_STAT) begin
      rdata_d = {4'h0, q_flags};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------
  // registered so the pin never glitches on a flag update
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= x86_irq | q_irq;
    end
  end

  // ----------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------
  assign o_rdata = rdata_q;
  assign o_mon_byte_count = mon_byte_q;
  assign o_mon_abort_count = mon_abort_q;
  assign o_counter_reset = counter_reset_q;
  assign o_irq = irq_q;
endmodule : srq_status_regs
`default_nettype wire

// ===== src/srq_sticky_flags.sv
// four sticky event flags with clear-on-read and masked request
`include "srq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srq_sticky_flags (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // events and control
  input wire srq_pkg::srq_flags_t i_event,
  input wire logic i_clear,
  input wire srq_pkg::srq_flags_t i_enable,
  // state
  output srq_pkg::srq_flags_t o_flags,
  output logic o_irq
);
  srq_pkg::srq_flags_t flags_q;

  genvar g;
  generate
    for (g = 0; g < `SRQ_FLAGS; g = g + 1) begin : g_flag
      // a set in the clear cycle wins, so no event is lost
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          flags_q[g] <= 1'b0;
        end else if (i_event[g]) begin
          flags_q[g] <= 1'b1;
        end else if (i_clear) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_flags = flags_q;
  assign o_irq = |(flags_q & i_enable);
endmodule : srq_sticky_flags
`default_nettype wire

// ===== src/srq_watermark.sv
// queue fill threshold crossing detector
`include "srq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srq_watermark (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // fill and threshold
  input wire logic [`SRQ_FILL_W-1:0] i_fill,
  input wire srq_pkg::srq_byte_t i_threshold,
  // crossing pulse
  output logic o_cross
);
  logic above_q;
  logic above_d;
  logic seen_q;
  logic [`SRQ_FILL_W-1:0] level;

  // threshold byte times 32 x 2048 bytes
  assign level = {i_threshold, {`SRQ_STEP_SHIFT{1'b0}}};
  assign above_d = (i_fill >= level);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      above_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      above_q <= above_d;
      seen_q <= 1'b1;
    end
  end

  // either direction counts as a crossing; first cycle only primes
  assign o_cross = seen_q && (above_d != above_q);
endmodule : srq_watermark
`default_nettype wire

// ===== verification/srq_status_regs_chk.sv
// port assertions for the serial rx status registers
`include "srq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module srq_status_regs_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // processor port
  input wire logic [`SRQ_ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire srq_pkg::srq_byte_t i_wdata,
  input wire srq_pkg::srq_byte_t o_rdata,
  // events and monitor
  input wire logic i_hdr_valid,
  input wire logic [`SRQ_FILL_W-1:0] i_queue_fill,
  input wire logic i_queue_ovf,
  input wire logic i_fifo_ovf,
  input wire logic [`SRQ_CNT_W-1:0] i_byte_count,
  input wire logic [`SRQ_CNT_W-1:0] o_mon_byte_count,
  input wire logic o_counter_reset,
  input wire logic o_irq
);
  // ------
  // checks
  // ------
  logic [1:0] ovf_q, ovf_d;
  logic [`SRQ_FILL_W-1:0] fill_q;
  logic calm, moved, rx, rq;
  logic stir, wr_req;
  // quiet cycle: nothing but a fill change could set a flag
  assign calm = !i_hdr_valid && !i_queue_ovf && !i_fifo_ovf && !i_wr;
  assign moved = i_queue_fill != fill_q;
  assign rx = i_rd && i_addr == `SRQ_OFS_X86_STAT;
  assign rq = i_rd && i_addr == `SRQ_OFS_Q_STAT;
  // anything that may set a flag or an enable in this cycle
  assign stir = !calm || moved;
  assign wr_req = i_wr && i_addr == `SRQ_OFS_UPD_REQ && i_wdata[0];
  // an event in the read cycle must survive the clear
  assign ovf_d = {i_fifo_ovf, i_queue_ovf} | (rq ? 2'b00 : ovf_q);
  always_ff @(posedge i_clk_sys) begin
    fill_q <= i_queue_fill;
    ovf_q <= i_rst_n ? ovf_d : 2'b00;
  end
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  a_hdr_read_clear: assert property (
    (rx && calm) [*2] |=> o_rdata == 8'h00)
    else $error("x86 status kept after read");
  a_queue_read_clear: assert property (
    (calm && !moved) ##1 (rq && calm && !moved) [*2] |=> o_rdata == 8'h00)
    else $error("queue status kept after read");
  a_ovf_flags_read: assert property (
    rq |=> o_rdata[3:2] == $past(ovf_q))
    else $error("overflow flags read wrong");
  a_irq_has_cause: assert property (
    $rose(o_irq) |-> $past(stir, 2) || $past(i_wr, 3))
    else $error("interrupt rose without a cause");
  a_upd_trigger: assert property (
    $rose(o_counter_reset) |-> $past(wr_req, 2))
    else $error("counter reset without update request");
  a_upd_pulse: assert property (
    o_counter_reset |=> !o_counter_reset)
    else $error("counter reset too long");
  a_upd_snapshot: assert property (
    o_counter_reset |-> o_mon_byte_count == $past(i_byte_count))
    else $error("byte count snapshot wrong");
  a_mon_hold: assert property (
    !o_counter_reset |-> $stable(o_mon_byte_count))
    else $error("snapshot moved without update");
  a_done_set: assert property (
    $rose(o_counter_reset) ##1 (i_rd && i_addr == `SRQ_OFS_UPD_DONE)
      |=> o_rdata[0] == 1'b1)
    else $error("update done flag not set");
endmodule : srq_status_regs_chk

bind srq_status_regs srq_status_regs_chk u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n),
  .i_addr(i_addr),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_hdr_valid(i_hdr_valid),
  .i_queue_fill(i_queue_fill),
  .i_queue_ovf(i_queue_ovf),
  .i_fifo_ovf(i_fifo_ovf),
  .i_byte_count(i_byte_count),
  .o_mon_byte_count(o_mon_byte_count),
  .o_counter_reset(o_counter_reset),
  .o_irq(o_irq)
);

`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the serial rx status registers
`include "srq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  // -----
  // bench
  // -----
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_hdr_valid = 1'b0, rd_d = 1'b0;
  logic i_queue_ovf = 1'b0, i_fifo_ovf = 1'b0, o_counter_reset, o_irq;
  logic [`SRQ_ADDR_W-1:0] i_addr = 9'h000, st, ie;
  logic [`SRQ_FILL_W-1:0] i_queue_fill = 24'hffffff;
  logic [`SRQ_CNT_W-1:0] i_byte_count = 32'h0, i_abort_count = 32'h0;
  logic [`SRQ_CNT_W-1:0] o_mon_byte_count, o_mon_abort_count;
  srq_pkg::srq_byte_t i_wdata = 8'h00, o_rdata, b, exp_q [$];
  // address, control, sapi low, sapi high
  srq_pkg::srq_byte_t hf [4] = '{default: 8'h00};
  srq_pkg::srq_byte_t ef [4] = '{default: 8'h00};
  int n_errors = 0, n_compared = 0, cyc = 0, seed = 6671, k;
  srq_status_regs DUT (
    .i_clk_sys, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
    .i_hdr_valid, .i_hdr_addr(hf[0]), .i_hdr_ctrl(hf[1]),
    .i_hdr_sapi_l(hf[2]), .i_hdr_sapi_h(hf[3]),
    .i_expected_address_field(ef[0]), .i_expected_control_field(ef[1]),
    .i_expected_sapi_low_octet(ef[2]), .i_expected_sapi_high_octet(ef[3]),
    .i_queue_fill, .i_queue_ovf, .i_fifo_ovf, .i_byte_count, .i_abort_count,
    .o_mon_byte_count, .o_mon_abort_count, .o_counter_reset, .o_irq
  );
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(bit ok, string m);
    n_compared++;
    if (!ok) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // one bus cycle; strobes stay up until the next call changes them
  task automatic bus(bit w, bit r, logic [8:0] a, srq_pkg::srq_byte_t d);
    i_wr = w;
    i_rd = r;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk_sys);
    #1;
  endtask : bus
  task automatic rd(logic [8:0] a, srq_pkg::srq_byte_t e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic idle(int n);
    repeat (n) bus(1'b0, 1'b0, 9'h000, 8'h00);
  endtask : idle
  task automatic cause(int f);
    int j;
    int thr;
    thr = f == 5 ? 5 : 2;
    if (f == 7) i_fifo_ovf = 1'b1;
    else if (f == 6) i_queue_ovf = 1'b1;
    else if (f > 3) begin
      i_queue_fill = 24'(thr * 32 * 2048);
      idle(1);
      rd(`SRQ_OFS_Q_STAT, 8'h00);
      i_queue_fill = 24'(thr * 32 * 2048 - 1);
    end else begin
      for (j = 0; j < 4; j++) begin
        ef[j] = 8'($random(seed));
        hf[j] = j == f ? ~ef[j] : ef[j];
      end
      i_hdr_valid = 1'b1;
    end
    idle(1);
    i_fifo_ovf = 1'b0;
    i_queue_ovf = 1'b0;
    i_hdr_valid = 1'b0;
  endtask : cause
  // read data lands one cycle after the read edge
  always @(posedge i_clk_sys) begin
    rd_d <= i_rd;
    cyc <= cyc + 1;
    if (rd_d) chk(o_rdata === exp_q.pop_front(), "read data");
    if (cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    bus(1'b1, 1'b0, `SRQ_OFS_UPD_DONE, 8'hff);
    bus(1'b1, 1'b0, `SRQ_OFS_Q_STAT, 8'hff);
    for (k = 0; k < 9; k++) rd(9'h120 + 9'(k), 8'h00);
    bus(1'b1, 1'b0, `SRQ_OFS_Q_LOW, 8'h02);
    bus(1'b1, 1'b0, `SRQ_OFS_Q_HIGH, 8'h05);
    rd(`SRQ_OFS_Q_LOW, 8'h02);
    rd(`SRQ_OFS_Q_HIGH, 8'h05);
    $display("test registers done");
    // high is crossed before low, so fill only falls
    for (k = 7; k >= 0; k--) begin
      st = k > 3 ? `SRQ_OFS_Q_STAT : `SRQ_OFS_X86_STAT;
      ie = k > 3 ? `SRQ_OFS_Q_IEN : `SRQ_OFS_X86_IEN;
      b = 8'h01 << (k % 4);
      bus(1'b1, 1'b0, ie, 8'h00);
      cause(k);
      idle(2);
      chk(o_irq === 1'b0, "masked flag raised irq");
      bus(1'b1, 1'b0, ie, b);
      idle(2);
      chk(o_irq === 1'b1, "enabled flag gave no irq");
      rd(ie, b);
      rd(st, b);
      rd(st, 8'h00);
      idle(2);
      chk(o_irq === 1'b0, "irq kept after read");
      $display("test flag %0d done", k);
    end
    i_byte_count = $random(seed);
    i_abort_count = $random(seed);
    bus(1'b1, 1'b0, `SRQ_OFS_UPD_REQ, 8'h01);
    for (k = 0; k < 8 && o_counter_reset !== 1'b1; k++) idle(1);
    chk(o_counter_reset === 1'b1, "no counter reset");
    chk(o_mon_abort_count === i_abort_count, "abort snapshot");
    chk(o_mon_byte_count === i_byte_count, "byte snapshot");
    idle(1);
    rd(`SRQ_OFS_UPD_DONE, 8'h01);
    bus(1'b1, 1'b0, `SRQ_OFS_UPD_REQ, 8'h00);
    idle(3);
    rd(`SRQ_OFS_UPD_DONE, 8'h00);
    idle(1);
    $display("test update done");
    wrap_up();
  end
endmodule : tb

`default_nettype wire
